/* File: src/omc_pkg.sv */
package omc_pkg;
   // operating modes, one-hot
   typedef enum logic [5:0] {
      OMC_INIT      = 6'h01,
      OMC_NORMAL    = 6'h02,
      OMC_STOP      = 6'h04,
      OMC_SLEEP     = 6'h08,
      OMC_RESTART   = 6'h10,
      OMC_FAIL_SAFE = 6'h20
   } omc_mode_t;

   // one serial frame: command byte then 24 data bits
   typedef struct packed {
      logic [7:0]  cmd;
      logic [23:0] data;
   } omc_frame_t;

   localparam int unsigned FRAME_BITS   = 32;
   localparam int unsigned CNT_W        = 6;

   localparam logic [7:0]  CMD_GO_NORMAL = 8'h01;
   localparam logic [7:0]  CMD_GO_STOP   = 8'h02;
   localparam logic [7:0]  CMD_GO_SLEEP  = 8'h03;
   localparam logic [7:0]  CMD_SOFT_RST  = 8'h04;
   localparam logic [7:0]  CMD_WD_TRIG   = 8'h05;
   localparam logic [7:0]  CMD_WD_RST_EN = 8'h06;

   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned T_RD_US      = 10;
   localparam int unsigned RD_CYC       = T_RD_US * CLK_MHZ;
   localparam int unsigned T_INT_US     = 1;
   localparam int unsigned INT_CYC      = T_INT_US * CLK_MHZ;
   localparam int unsigned T_LW_MS      = 200;
   localparam int unsigned LW_CYC       = T_LW_MS * 1000 * CLK_MHZ;
   localparam int unsigned T_WD_MS      = 20;
   localparam int unsigned WD_CYC       = T_WD_MS * 1000 * CLK_MHZ;

   localparam logic        RST_ACTIVE   = 1'b0;
endpackage : omc_pkg

/* File: src/omc_spi_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module omc_spi_rx (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               spi_sclk,
   input  wire logic               spi_csn,
   input  wire logic               spi_mosi,
   output logic                    in_frame,
   output logic                    frame_valid,
   output omc_pkg::omc_frame_t     frame
);
   logic [2:0]                  sclk_sync_ff;
   logic [2:0]                  csn_sync_ff;
   logic [1:0]                  mosi_sync_ff;
   logic [31:0]                 shift_ff;
   logic [31:0]                 nxt_shift;
   logic [omc_pkg::CNT_W-1:0]   bits_ff;
   logic [omc_pkg::CNT_W-1:0]   nxt_bits;
   logic                        valid_ff;
   logic                        nxt_valid;

   // link clock is sampled, so it must stay well below clk/4
   always_comb
   begin
      nxt_shift = shift_ff;
      nxt_bits  = bits_ff;
      nxt_valid = 1'b0;
      if (!csn_sync_ff[1] && sclk_sync_ff[1] && !sclk_sync_ff[2])
      begin
         nxt_shift = {shift_ff[30:0], mosi_sync_ff[1]};
         // saturate one past a full frame so an overlong frame is refused too
         if (bits_ff != omc_pkg::CNT_W'(omc_pkg::FRAME_BITS + 1))
            nxt_bits = bits_ff + 1'b1;
      end
      if (csn_sync_ff[1] && !csn_sync_ff[2])
      begin
         nxt_valid = (bits_ff == omc_pkg::CNT_W'(omc_pkg::FRAME_BITS));
         nxt_bits  = '0;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sclk_sync_ff <= 3'h0;
         csn_sync_ff  <= 3'h7;
         mosi_sync_ff <= 2'h0;
         shift_ff     <= 32'h0;
         bits_ff      <= '0;
         valid_ff     <= 1'b0;
      end
      else
      begin
         sclk_sync_ff <= {sclk_sync_ff[1:0], spi_sclk};
         csn_sync_ff  <= {csn_sync_ff[1:0], spi_csn};
         mosi_sync_ff <= {mosi_sync_ff[0], spi_mosi};
         shift_ff     <= nxt_shift;
         bits_ff      <= nxt_bits;
         valid_ff     <= nxt_valid;
      end
   end

   assign in_frame    = !csn_sync_ff[1] || !csn_sync_ff[2];
   assign frame_valid = valid_ff;
   assign frame       = shift_ff;
endmodule : omc_spi_rx
`default_nettype wire

/* File: src/omc_mode_ctrl.sv */
// Notes on behaviour
// - init mode after power-on reset and after a soft reset command
// - normal mode is the main working state
// - stop mode keeps the main regulator output on
// - sleep mode switches the main regulator output off
// - wake in sleep or fail-safe, watchdog failure or undervoltage go to restart
// - restart mode drives the reset output low
// - temperature shutdown goes to fail-safe mode
// - development overlay leaves every mode reachable as usual
// - in the overlay a watchdog failure does not drive reset
// - in the overlay a watchdog failure pulses the interrupt pin
// - watchdog reset can be re-enabled inside the overlay
// - watchdog always starts with the long open window
// - control arrives as 32-bit serial frames
// - configuration only over the serial link, which is receive-only
// - after power-on the watchdog starts once reset is released
// - init mode waits for the microcontroller before moving on
// - pin held low plus the first frame in init after power-on latches the overlay
`timescale 1ns/1ps
`default_nettype none
module omc_mode_ctrl #(
   parameter logic [31:0] LW_CYC = omc_pkg::LW_CYC,
   parameter logic [31:0] WD_CYC = omc_pkg::WD_CYC
) (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               spi_sclk,
   input  wire logic               spi_csn,
   input  wire logic               spi_mosi,
   input  wire logic               intn_in,
   input  wire logic               wake_event,
   input  wire logic               temp_shutdown,
   input  wire logic               main_regulator_output_undervoltage,
   output logic                    intn_out,
   output logic                    intn_oe,
   output logic                    reset_output_low,
   output logic                    main_regulator_output,
   output omc_pkg::omc_mode_t      mode,
   output logic                    sw_dev_mode
);
   logic                 in_frame;
   logic                 frame_valid;
   omc_pkg::omc_frame_t  frame;
   logic [1:0]           intn_sync_ff;
   logic [1:0]           wake_sync_ff;
   logic [1:0]           tsd_sync_ff;
   logic [1:0]           uv_sync_ff;

   omc_pkg::omc_mode_t   state_ff;
   omc_pkg::omc_mode_t   nxt_state;
   logic [15:0]          rd_cnt_ff;
   logic [15:0]          nxt_rd_cnt;
   logic [31:0]          wd_cnt_ff;
   logic [31:0]          nxt_wd_cnt;
   logic                 wd_run_ff;
   logic                 nxt_wd_run;
   logic                 sw_dev_ff;
   logic                 nxt_sw_dev;
   logic                 wd_rst_en_ff;
   logic                 nxt_wd_rst_en;
   logic                 por_init_ff;
   logic                 nxt_por_init;
   logic                 first_cmd_ff;
   logic                 nxt_first_cmd;
   logic [15:0]          int_cnt_ff;
   logic [15:0]          nxt_int_cnt;
   logic                 rst_out_ff;
   logic                 nxt_rst_out;
   logic                 reg_on_ff;
   logic                 nxt_reg_on;
   logic                 intn_oe_ff;
   logic                 wd_expire;
   logic                 wd_resets;
   logic                 ev_ok;
   logic                 released;
   logic [7:0]           cmd;

   omc_spi_rx u_spi_rx (
      .clk         (clk),
      .reset_n     (reset_n),
      .spi_sclk    (spi_sclk),
      .spi_csn     (spi_csn),
      .spi_mosi    (spi_mosi),
      .in_frame    (in_frame),
      .frame_valid (frame_valid),
      .frame       (frame)
   );

   assign cmd       = frame.cmd;
   assign wd_expire = wd_run_ff && (wd_cnt_ff == 32'h1);
   assign wd_resets = !sw_dev_ff || wd_rst_en_ff;
   // pin events wait until the link is idle
   assign ev_ok     = !in_frame;
   assign released  = (rd_cnt_ff == 16'(omc_pkg::RD_CYC));

   always_comb
   begin
      nxt_state     = state_ff;
      nxt_rd_cnt    = rd_cnt_ff;
      nxt_wd_cnt    = wd_cnt_ff;
      nxt_wd_run    = wd_run_ff;
      nxt_sw_dev    = sw_dev_ff;
      nxt_wd_rst_en = wd_rst_en_ff;
      nxt_por_init  = por_init_ff;
      nxt_first_cmd = first_cmd_ff;
      nxt_int_cnt   = (int_cnt_ff != 16'h0) ? int_cnt_ff - 16'h1 : 16'h0;
      if (wd_run_ff && wd_cnt_ff != 32'h0)
         nxt_wd_cnt = wd_cnt_ff - 32'h1;
      if (frame_valid && cmd == omc_pkg::CMD_WD_TRIG && wd_run_ff)
         nxt_wd_cnt = WD_CYC;
      // reset signalling switched back on by command
      if (frame_valid && cmd == omc_pkg::CMD_WD_RST_EN)
         nxt_wd_rst_en = 1'b1;
      // the overlay only changes the watchdog action, never the modes
      case (state_ff)
         omc_pkg::OMC_INIT:
         begin
            if (!released)
               nxt_rd_cnt = rd_cnt_ff + 16'h1;
            else if (frame_valid)
            begin
               // pin low at the first frame after power-up
               if (first_cmd_ff && por_init_ff && !intn_sync_ff[1])
                  nxt_sw_dev = 1'b1;
               nxt_first_cmd = 1'b0;
               // leave init for normal only on the host's go command
               if (cmd == omc_pkg::CMD_GO_NORMAL)
                  nxt_state = omc_pkg::OMC_NORMAL;
            end
         end
         omc_pkg::OMC_NORMAL:
         begin
            if (frame_valid && cmd == omc_pkg::CMD_SOFT_RST)
            begin
               nxt_state  = omc_pkg::OMC_INIT;
               nxt_rd_cnt = 16'h0;
               nxt_wd_run = 1'b0;
            end
            else if (frame_valid && cmd == omc_pkg::CMD_GO_STOP)
               nxt_state = omc_pkg::OMC_STOP;
            else if (frame_valid && cmd == omc_pkg::CMD_GO_SLEEP)
            begin
               nxt_state  = omc_pkg::OMC_SLEEP;
               nxt_wd_run = 1'b0;
            end
         end
         omc_pkg::OMC_STOP:
         begin
            if ((frame_valid && cmd == omc_pkg::CMD_GO_NORMAL) || (wake_sync_ff[1] && ev_ok))
               nxt_state = omc_pkg::OMC_NORMAL;
         end
         omc_pkg::OMC_SLEEP, omc_pkg::OMC_FAIL_SAFE:
         begin
            if (wake_sync_ff[1] && ev_ok)
            begin
               nxt_state  = omc_pkg::OMC_RESTART;
               nxt_rd_cnt = 16'h0;
            end
         end
         omc_pkg::OMC_RESTART:
         begin
            if (!released)
               nxt_rd_cnt = rd_cnt_ff + 16'h1;
            else
               nxt_state = omc_pkg::OMC_NORMAL;
         end
         default:
            nxt_state = omc_pkg::OMC_INIT;
      endcase
      // failures force a restart once reset is released
      if (released && ev_ok && (state_ff == omc_pkg::OMC_NORMAL ||
          state_ff == omc_pkg::OMC_STOP || state_ff == omc_pkg::OMC_INIT))
      begin
         if ((wd_expire && wd_resets) || uv_sync_ff[1])
         begin
            nxt_state  = omc_pkg::OMC_RESTART;
            nxt_rd_cnt = 16'h0;
            nxt_wd_run = 1'b0;
         end
      end
      // an expiry that falls inside a frame stays pending until the link is idle
      if (wd_expire && wd_resets && !ev_ok)
         nxt_wd_cnt = wd_cnt_ff;
      // overlay failure restarts the long window instead of a reset
      if (wd_expire && !wd_resets)
      begin
         nxt_wd_cnt  = LW_CYC;
         // failure shown on the interrupt pin
         nxt_int_cnt = 16'(omc_pkg::INT_CYC);
      end
      // overtemperature wins over every other request except a wake in fail-safe
      if (tsd_sync_ff[1] && ev_ok && state_ff != omc_pkg::OMC_FAIL_SAFE)
      begin
         nxt_state  = omc_pkg::OMC_FAIL_SAFE;
         nxt_wd_run = 1'b0;
      end
      // every watchdog start uses the long window
      if (!wd_run_ff && nxt_state != omc_pkg::OMC_SLEEP && nxt_state != omc_pkg::OMC_FAIL_SAFE
          && ((nxt_state == omc_pkg::OMC_INIT && nxt_rd_cnt == 16'(omc_pkg::RD_CYC))
          || nxt_state == omc_pkg::OMC_NORMAL || nxt_state == omc_pkg::OMC_STOP))
      begin
         nxt_wd_run = 1'b1;
         nxt_wd_cnt = LW_CYC;
      end
      if (nxt_state != omc_pkg::OMC_INIT)
         nxt_por_init = 1'b0;
      // reset low during delay in init and restart, and in fail-safe
      nxt_rst_out = !((nxt_state == omc_pkg::OMC_INIT && nxt_rd_cnt != 16'(omc_pkg::RD_CYC))
                   || (nxt_state == omc_pkg::OMC_RESTART && nxt_rd_cnt != 16'(omc_pkg::RD_CYC))
                   || nxt_state == omc_pkg::OMC_FAIL_SAFE);
      // regulator off only in sleep and fail-safe
      nxt_reg_on  = !(nxt_state == omc_pkg::OMC_SLEEP || nxt_state == omc_pkg::OMC_FAIL_SAFE);
   end

   // mode register cleared to init by reset
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         intn_sync_ff <= 2'h3;
         wake_sync_ff <= 2'h0;
         tsd_sync_ff  <= 2'h0;
         uv_sync_ff   <= 2'h0;
         state_ff     <= omc_pkg::OMC_INIT;
         rd_cnt_ff    <= 16'h0;
         wd_cnt_ff    <= 32'h0;
         wd_run_ff    <= 1'b0;
         sw_dev_ff    <= 1'b0;
         wd_rst_en_ff <= 1'b0;
         por_init_ff  <= 1'b1;
         first_cmd_ff <= 1'b1;
         int_cnt_ff   <= 16'h0;
         rst_out_ff   <= omc_pkg::RST_ACTIVE;
         reg_on_ff    <= 1'b1;
         intn_oe_ff   <= 1'b0;
      end
      else
      begin
         intn_sync_ff <= {intn_sync_ff[0], intn_in};
         wake_sync_ff <= {wake_sync_ff[0], wake_event};
         tsd_sync_ff  <= {tsd_sync_ff[0], temp_shutdown};
         uv_sync_ff   <= {uv_sync_ff[0], main_regulator_output_undervoltage};
         state_ff     <= nxt_state;
         rd_cnt_ff    <= nxt_rd_cnt;
         wd_cnt_ff    <= nxt_wd_cnt;
         wd_run_ff    <= nxt_wd_run;
         sw_dev_ff    <= nxt_sw_dev;
         wd_rst_en_ff <= nxt_wd_rst_en;
         por_init_ff  <= nxt_por_init;
         first_cmd_ff <= nxt_first_cmd;
         int_cnt_ff   <= nxt_int_cnt;
         rst_out_ff   <= nxt_rst_out;
         reg_on_ff    <= nxt_reg_on;
         intn_oe_ff   <= (nxt_int_cnt != 16'h0);
      end
   end

   // no path other than the serial frames changes configuration
   assign intn_out              = 1'b0;
   assign intn_oe               = intn_oe_ff;
   assign reset_output_low      = rst_out_ff;
   assign main_regulator_output = reg_on_ff;
   assign mode                  = state_ff;
   assign sw_dev_mode           = sw_dev_ff;

   a_soft_rst_init: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == omc_pkg::OMC_NORMAL && frame_valid && cmd == omc_pkg::CMD_SOFT_RST
      && !(tsd_sync_ff[1] && ev_ok) && !uv_sync_ff[1] && !wd_expire
      |=> state_ff == omc_pkg::OMC_INIT && !reset_output_low)
      else $error("soft reset did not re-enter init with reset low");
   a_init_to_normal: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == omc_pkg::OMC_INIT && !frame_valid && !tsd_sync_ff[1] && !uv_sync_ff[1]
      && !wd_expire |=> state_ff == omc_pkg::OMC_INIT)
      else $error("init left without a go command");
   a_stop_reg_on: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == omc_pkg::OMC_STOP |-> main_regulator_output)
      else $error("regulator off in stop mode");
   a_sleep_reg_off: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == omc_pkg::OMC_SLEEP |-> !main_regulator_output)
      else $error("regulator on in sleep mode");
   a_sleep_wake: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == omc_pkg::OMC_SLEEP && wake_sync_ff[1] && ev_ok && !tsd_sync_ff[1]
      |=> state_ff == omc_pkg::OMC_RESTART)
      else $error("wake in sleep did not go to restart");
   a_restart_rst: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(state_ff == omc_pkg::OMC_RESTART) |-> !reset_output_low [*8])
      else $error("reset not held low in restart");
   a_tsd_failsafe: assert property (@(posedge clk) disable iff (!reset_n)
      tsd_sync_ff[1] && ev_ok |=> state_ff == omc_pkg::OMC_FAIL_SAFE && !main_regulator_output)
      else $error("overtemperature did not reach fail-safe");
   a_dev_no_rst: assert property (@(posedge clk) disable iff (!reset_n)
      wd_expire && !wd_resets && (state_ff == omc_pkg::OMC_NORMAL
      || state_ff == omc_pkg::OMC_INIT) && !tsd_sync_ff[1]
      && !uv_sync_ff[1] |=> state_ff != omc_pkg::OMC_RESTART && reset_output_low)
      else $error("overlay watchdog failure caused a reset");
   a_dev_intn: assert property (@(posedge clk) disable iff (!reset_n)
      wd_expire && !wd_resets |=> intn_oe [*8])
      else $error("overlay watchdog failure not on interrupt pin");
   a_wd_long_start: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(wd_run_ff) |-> wd_cnt_ff == LW_CYC)
      else $error("watchdog did not start with long window");
   a_por_wd_start: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(reset_output_low) && state_ff == omc_pkg::OMC_INIT |-> wd_run_ff)
      else $error("watchdog not started at reset release");
endmodule : omc_mode_ctrl
`default_nettype wire

/* File: bench/omc_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module omc_spi_host (
   input  wire logic   clk,
   output logic        spi_sclk,
   output logic        spi_csn,
   output logic        spi_mosi
);
   initial
   begin
      spi_sclk = 1'b0;
      spi_csn  = 1'b1;
      spi_mosi = 1'b0;
   end
   task automatic send(input omc_pkg::omc_frame_t f, input int nbits);
      @(posedge clk);
      #1 spi_csn = 1'b0;
      for (int i = 31; i > 31 - nbits; i--)
      begin
         spi_mosi = f[i];
         #80 spi_sclk = 1'b1;
         #80 spi_sclk = 1'b0;
      end
      #80 spi_csn = 1'b1;
      // released line shows the inverse so a stale bit is never trusted
      spi_mosi = ~spi_mosi;
   endtask : send
endmodule : omc_spi_host
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [31:0] LW = 32'h00001f40;
   localparam logic [31:0] WD = 32'h00000fa0;
   logic                   clk = 1'b0;
   logic                   reset_n = 1'b0;
   logic                   pull = 1'b1;
   logic                   wake = 1'b0;
   logic                   temp = 1'b0;
   logic                   uv = 1'b0;
   wire logic              sclk;
   wire logic              csn;
   wire logic              mosi;
   wire logic              intn_pin;
   logic                   intn_out;
   logic                   intn_oe;
   logic                   rst_low;
   logic                   reg_on;
   omc_pkg::omc_mode_t     mode;
   logic                   sw_dev;
   omc_pkg::omc_mode_t     exp_mode;
   int                     num_errors = 0;
   int                     n_compared = 0;
   int                     seed = 66609;
   int                     n;
   logic [7:0]             cq[$];
   // open-drain pin with the bench's pull level
   assign intn_pin = (intn_oe === 1'b1) ? intn_out : pull;
   always #5 clk = ~clk;
   omc_spi_host i_host (.clk(clk), .spi_sclk(sclk), .spi_csn(csn), .spi_mosi(mosi));
   omc_mode_ctrl #(.LW_CYC(LW), .WD_CYC(WD)) i_dut (
      .clk(clk), .reset_n(reset_n), .spi_sclk(sclk), .spi_csn(csn), .spi_mosi(mosi),
      .intn_in(intn_pin), .wake_event(wake), .temp_shutdown(temp),
      .main_regulator_output_undervoltage(uv), .intn_out(intn_out), .intn_oe(intn_oe),
      .reset_output_low(rst_low), .main_regulator_output(reg_on), .mode(mode),
      .sw_dev_mode(sw_dev));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("compares %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   // sel 0 mode, 1 reset released, 2 interrupt pulse
   task automatic wait_for(input int sel, input omc_pkg::omc_mode_t m, input int maxc,
                           output int cyc);
      cyc = 0;
      while (!((sel == 0 && mode === m) || (sel == 1 && rst_low === 1'b1) ||
               (sel == 2 && intn_oe === 1'b1)))
      begin
         @(posedge clk);
         #1;
         cyc++;
         if (cyc > maxc)
         begin
            num_errors++;
            $display("CHECK FAILED wait %0d expected done seen timeout", sel);
            finish_test();
         end
      end
   endtask : wait_for
   function automatic omc_pkg::omc_mode_t model(input omc_pkg::omc_mode_t m,
                                                input logic [7:0] c);
      if (c === omc_pkg::CMD_GO_NORMAL && (m == omc_pkg::OMC_INIT || m == omc_pkg::OMC_STOP))
         return omc_pkg::OMC_NORMAL;
      if (m != omc_pkg::OMC_NORMAL)
         return m;
      if (c === omc_pkg::CMD_GO_STOP)
         return omc_pkg::OMC_STOP;
      if (c === omc_pkg::CMD_GO_SLEEP)
         return omc_pkg::OMC_SLEEP;
      if (c === omc_pkg::CMD_SOFT_RST)
         return omc_pkg::OMC_INIT;
      return m;
   endfunction : model
   task automatic frame(input logic [7:0] c, input int nbits);
      i_host.send({c, 24'($random(seed))}, nbits);
      repeat (10) @(posedge clk);
      if (nbits == 32)
         exp_mode = model(exp_mode, c);
      // mode follows command after the frame
      check("mode", 32'(mode), 32'(exp_mode));
      check("regulator", 32'(reg_on), 32'(exp_mode != omc_pkg::OMC_SLEEP));
   endtask : frame
   task automatic pin(input int which, input omc_pkg::omc_mode_t m);
      @(posedge clk);
      #1;
      if (which == 0) wake = 1'b1;
      if (which == 1) temp = 1'b1;
      if (which == 2) uv = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check("pin mode", 32'(mode), 32'(m));
      wake = 1'b0;
      temp = 1'b0;
      uv = 1'b0;
      exp_mode = m;
   endtask : pin
   task automatic power_up();
      reset_n = 1'b0;
      repeat (5) @(posedge clk);
      check("reset mode", 32'(mode), 32'(omc_pkg::OMC_INIT));
      check("reset out", 32'(rst_low), 32'h0);
      #1 reset_n = 1'b1;
      exp_mode = omc_pkg::OMC_INIT;
      wait_for(1, mode, 1100, n);
      // init waits before releasing the host
      check("init wait", 32'(n), 32'(omc_pkg::RD_CYC));
   endtask : power_up
   initial
   begin
      power_up();
      cq = '{omc_pkg::CMD_GO_STOP, omc_pkg::CMD_GO_NORMAL, omc_pkg::CMD_GO_STOP};
      foreach (cq[i])
         frame(cq[i], 32);
      pin(0, omc_pkg::OMC_NORMAL);
      frame(omc_pkg::CMD_GO_SLEEP, 32);
      // wake from sleep, then temperature and undervoltage
      pin(0, omc_pkg::OMC_RESTART);
      check("restart reset", 32'(rst_low), 32'h0);
      wait_for(0, omc_pkg::OMC_NORMAL, 1100, n);
      pin(1, omc_pkg::OMC_FAIL_SAFE);
      check("fs regulator", 32'(reg_on), 32'h0);
      pin(0, omc_pkg::OMC_RESTART);
      wait_for(0, omc_pkg::OMC_NORMAL, 1100, n);
      pin(2, omc_pkg::OMC_RESTART);
      wait_for(0, omc_pkg::OMC_NORMAL, 1100, n);
      exp_mode = omc_pkg::OMC_NORMAL;
      frame(omc_pkg::CMD_GO_STOP, 31);
      frame(omc_pkg::CMD_SOFT_RST, 32);
      wait_for(1, mode, 1100, n);
      wait_for(0, omc_pkg::OMC_RESTART, LW + 100, n);
      // first window is the long one
      check("long window", 32'(n >= LW - 20), 32'h1);
      check("overlay off", 32'(sw_dev), 32'h0);
      $display("test ordinary modes done");
      pull = 1'b0;
      power_up();
      frame(omc_pkg::CMD_WD_TRIG, 32);
      check("overlay", 32'(sw_dev), 32'h1);
      pull = 1'b1;
      wait_for(2, mode, WD + 100, n);
      check("wd mode", 32'(mode), 32'(omc_pkg::OMC_INIT));
      check("wd reset", 32'(rst_low), 32'h1);
      check("int pin", 32'(intn_pin), 32'h0);
      n = 0;
      while (intn_oe === 1'b1 && n < 200)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check("int width", 32'(n), 32'(omc_pkg::INT_CYC));
      frame(omc_pkg::CMD_GO_NORMAL, 32);
      frame(omc_pkg::CMD_WD_RST_EN, 32);
      wait_for(0, omc_pkg::OMC_RESTART, LW + WD + 100, n);
      check("wd reset back", 32'(rst_low), 32'h0);
      $display("test overlay done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
